//--- rtl/ramlt_pkg.sv
// Shared constants and carriers for the reset and mode latch block
package ramlt_pkg;
    // Cycles the strap must hold before the pin rises
    localparam int STRAP_WINDOW_CYCLES = 10;
    // Cycles from pin release to first fetch
    localparam int FETCH_DELAY_CYCLES = 80;
    // Reset value of the core program counter
    localparam logic [31:0] PC_RESET_VALUE = 32'h0000_0000;
    // Width of the peripheral pin bank
    localparam int PIN_COUNT = 32;
    // Boot width encodings latched from the boot width strap
    localparam logic BOOT_WIDTH_8 = 1'b1;
    localparam logic BOOT_WIDTH_16 = 1'b0;

    typedef enum logic [2:0] {
        RAMLT_IN_RESET = 3'b001,
        RAMLT_WAIT_FETCH = 3'b010,
        RAMLT_RUN = 3'b100
    } ramlt_state_e;

    // Latched start-up modes
    typedef struct packed {
        logic tristate_mode;
        logic boot_width_8bit;
    } ramlt_modes_s;

    // Control issued to the rest of the chip
    typedef struct packed {
        logic sys_reset;
        logic fetch_enable;
        logic core_clk_en;
        logic [31:0] fetch_addr;
    } ramlt_ctrl_s;
endpackage : ramlt_pkg

//--- rtl/ramlt_sync.sv
// Two-flop level synchroniser with asynchronous preset value
`timescale 1ns/1ns
module ramlt_sync #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic meta;
        logic stable;
    } ramlt_sync_s;

    ramlt_sync_s state_reg;
    ramlt_sync_s state_next;

    // First stage feeds only the second stage
    always_comb begin
        state_next.meta = d;
        state_next.stable = state_reg.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= {RESET_VALUE, RESET_VALUE};
        end else begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg.stable;
endmodule : ramlt_sync

//--- rtl/ramlt_reset_sync.sv
// Reset bridge: asserts at once, releases on the clock
`timescale 1ns/1ns
module ramlt_reset_sync (
    input wire logic clk,
    input wire logic arst,
    output logic rst_sync
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } ramlt_rsync_s;

    ramlt_rsync_s state_reg;
    ramlt_rsync_s state_next;

    // Shift zeros in after release; stage1 read only by stage2
    always_comb begin
        state_next.stage1 = 1'b0;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clk or posedge arst) begin
        if (arst) begin
            state_reg <= 2'b11;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rst_sync = state_reg.stage2;
endmodule : ramlt_reset_sync

//--- rtl/ramlt_top.sv
// Reset sequencer, strap latch, clock mirror and pin gating
`timescale 1ns/1ns

//
// Overview of operation
// - Pin reset asserts at once, release is stepped on the master clock.
// - First instruction fetch comes 80 cycles after the reset pin rises.
// - Any reset defaults peripheral registers and points next fetch at zero.
// - Watchdog reset acts like pin reset but keeps latched strap modes.
// - Pin reset together with watchdog reset counts as pin reset.
// - Tri-state strap low for final ten cycles before release enters tri-state.
// - Tri-state mode disables every output driver of the controller.
// - Master clock copy drives clock output pin unless I/O controller reclaims it.
// - Peripheral pins are inputs during reset; on leaving reset they follow periph_pin_oe at once unless tri-state mode is latched.
// - Idle mode stops core clock until the next interrupt arrives.
// - Boot width strap high picks 8-bit, low 16-bit boot memory.
module ramlt_top #(
    parameter int STRAP_CYCLES = ramlt_pkg::STRAP_WINDOW_CYCLES,
    parameter int FETCH_CYCLES = ramlt_pkg::FETCH_DELAY_CYCLES,
    parameter int PINS = ramlt_pkg::PIN_COUNT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_reset_n,
    input wire logic wdog_reset_req,
    input wire logic tristate_strap_n,
    input wire logic boot_width_strap,
    input wire logic idle_req,
    input wire logic irq_pending,
    input wire logic clkout_as_gpio,
    input wire logic [PINS-1:0] periph_pin_out,
    input wire logic [PINS-1:0] periph_pin_oe,
    input wire logic clkout_gpio_out,
    input wire logic clkout_gpio_oe,
    output ramlt_pkg::ramlt_ctrl_s ctrl,
    output ramlt_pkg::ramlt_modes_s modes,
    output logic periph_reset,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic master_clock_out,
    output logic master_clock_out_oe
);
    import ramlt_pkg::*;

    localparam int CW = $clog2(FETCH_CYCLES + 1);
    localparam int SW = $clog2(STRAP_CYCLES + 1);

    // Whole block state
    typedef struct packed {
        ramlt_state_e state;
        logic [CW-1:0] fetch_cnt;
        logic [SW-1:0] tri_low_cnt;
        logic boot_sample;
        logic tristate_mode;
        logic boot_width_8bit;
        logic core_asleep;
        logic pin_reset_seen;
    } ramlt_top_s;

    ramlt_top_s state_reg;
    ramlt_top_s state_next;

    logic pin_rst_async;
    logic pin_rst_sync;
    logic wdog_sync;
    logic tri_sync_n;
    logic boot_sync;
    logic any_reset;
    logic pin_released;

    // Saturating increment shared by both counters
    function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic [7:0] lim);
        sat_inc = (v >= lim) ? lim : v + 8'h01;
    endfunction : sat_inc

    assign pin_rst_async = rst | ~hw_reset_n;

    // Pin reset asserts without a clock, releases on it
    ramlt_reset_sync u_pin_rst (
        .clk(clk),
        .arst(pin_rst_async),
        .rst_sync(pin_rst_sync)
    );

    ramlt_sync #(.RESET_VALUE(1'b0)) u_wdog (
        .clk(clk),
        .rst(rst),
        .d(wdog_reset_req),
        .q(wdog_sync)
    );

    ramlt_sync #(.RESET_VALUE(1'b1)) u_tri (
        .clk(clk),
        .rst(rst),
        .d(tristate_strap_n),
        .q(tri_sync_n)
    );

    ramlt_sync #(.RESET_VALUE(1'b0)) u_boot (
        .clk(clk),
        .rst(rst),
        .d(boot_width_strap),
        .q(boot_sync)
    );

    // Watchdog alone resets core but not the strap latches
    assign any_reset = pin_rst_sync | wdog_sync;
    assign pin_released = state_reg.pin_reset_seen & ~pin_rst_sync;

    // Next-state logic for sequencing and strap capture
    always_comb begin
        state_next = state_reg;
        if (pin_rst_sync) begin
            // Pin wins over watchdog: straps are tracked here only
            state_next.pin_reset_seen = 1'b1;
            if (!tri_sync_n) begin
                state_next.tri_low_cnt = SW'(sat_inc(8'(state_reg.tri_low_cnt), 8'(STRAP_CYCLES)));
            end else begin
                state_next.tri_low_cnt = '0;
            end
            state_next.boot_sample = boot_sync;
        end
        if (pin_released) begin
            // Latch modes on the release edge; counter covers the final window
            state_next.tristate_mode = (32'(state_reg.tri_low_cnt) >= STRAP_CYCLES);
            state_next.boot_width_8bit = (state_reg.boot_sample == BOOT_WIDTH_8);
            state_next.pin_reset_seen = 1'b0;
            state_next.tri_low_cnt = '0;
        end
        if (any_reset) begin
            state_next.state = RAMLT_IN_RESET;
            state_next.fetch_cnt = '0;
            state_next.core_asleep = 1'b0;
        end else begin
            unique case (state_reg.state)
                RAMLT_IN_RESET: begin
                    state_next.state = RAMLT_WAIT_FETCH;
                    state_next.fetch_cnt = CW'(1);
                end
                RAMLT_WAIT_FETCH: begin
                    // Sync stages count toward the fetch delay
                    if (32'(state_reg.fetch_cnt) >= FETCH_CYCLES - 3) begin
                        state_next.state = RAMLT_RUN;
                    end else begin
                        state_next.fetch_cnt = CW'(sat_inc(8'(state_reg.fetch_cnt), 8'(FETCH_CYCLES)));
                    end
                end
                RAMLT_RUN: begin
                    // Wake on interrupt takes priority over sleep
                    if (irq_pending) begin
                        state_next.core_asleep = 1'b0;
                    end else if (idle_req) begin
                        state_next.core_asleep = 1'b1;
                    end
                end
                default: begin
                    state_next.state = RAMLT_IN_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg.state <= RAMLT_IN_RESET;
            state_reg.fetch_cnt <= '0;
            state_reg.tri_low_cnt <= '0;
            state_reg.boot_sample <= 1'b0;
            state_reg.tristate_mode <= 1'b0;
            state_reg.boot_width_8bit <= 1'b0;
            state_reg.core_asleep <= 1'b0;
            state_reg.pin_reset_seen <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Control outputs to core and peripherals
    always_comb begin
        ctrl.sys_reset = state_reg.state == RAMLT_IN_RESET;
        ctrl.fetch_enable = state_reg.state == RAMLT_RUN;
        ctrl.core_clk_en = (state_reg.state == RAMLT_RUN) & ~state_reg.core_asleep;
        ctrl.fetch_addr = PC_RESET_VALUE;
    end

    assign modes.tristate_mode = state_reg.tristate_mode;
    assign modes.boot_width_8bit = state_reg.boot_width_8bit;
    assign periph_reset = any_reset | (state_reg.state == RAMLT_IN_RESET);

    // Pins are inputs in reset; tri-state mode kills all drivers
    always_comb begin
        pin_out = periph_pin_out;
        // Reset term is async so drivers drop in the same cycle as the pin
        if (state_reg.tristate_mode || periph_reset) begin
            pin_oe = '0;
        end else begin
            pin_oe = periph_pin_oe;
        end
    end

    // Clock mirror is a gated data path, glitch hazard accepted for a test pin
    always_comb begin
        if (clkout_as_gpio && !periph_reset) begin
            master_clock_out = clkout_gpio_out;
            master_clock_out_oe = clkout_gpio_oe & ~state_reg.tristate_mode;
        end else begin
            master_clock_out = clk;
            master_clock_out_oe = ~state_reg.tristate_mode;
        end
    end
endmodule : ramlt_top

//--- tb/ramlt_top_asserts.sv
// Port checker for the reset and mode latch block
`timescale 1ns/1ns
module ramlt_chk import ramlt_pkg::*; #(
    parameter int STRAP_CYCLES = 10,
    parameter int FETCH_CYCLES = 80,
    parameter int PINS = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_reset_n,
    input wire logic wdog_reset_req,
    input wire logic tristate_strap_n,
    input wire logic boot_width_strap,
    input wire logic idle_req,
    input wire logic irq_pending,
    input wire logic clkout_as_gpio,
    input wire ramlt_pkg::ramlt_ctrl_s ctrl,
    input wire ramlt_pkg::ramlt_modes_s modes,
    input wire logic periph_reset,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic master_clock_out_oe
);
    logic [7:0] up_reg;
    logic [7:0] low_reg;
    logic ok_reg;
    logic tri_ok;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    assign tri_ok = low_reg >= STRAP_CYCLES;
    // Age since pin release; ok_reg drops if the watchdog muddles the timing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_reg <= 8'h00;
            low_reg <= 8'h00;
            ok_reg <= 1'b0;
        end else begin
            up_reg <= !hw_reset_n ? 8'h00 : up_reg + {7'h00, up_reg != 8'hFF};
            low_reg <= tristate_strap_n ? 8'h00 : low_reg + {7'h00, low_reg != 8'hFF};
            ok_reg <= !hw_reset_n || (ok_reg && !wdog_reset_req);
        end
    end
    property p_enter; !hw_reset_n |-> periph_reset; endproperty
    property p_leave; $rose(hw_reset_n) |-> ctrl.sys_reset; endproperty
    property p_early; $rose(ctrl.fetch_enable) && ok_reg |-> up_reg >= FETCH_CYCLES - 2; endproperty
    property p_late; ok_reg && up_reg == FETCH_CYCLES + 2 |-> ctrl.fetch_enable; endproperty
    property p_pc; ctrl.sys_reset |-> periph_reset && ctrl.fetch_addr == PC_RESET_VALUE; endproperty
    property p_keep; $changed(modes) |-> up_reg <= 6; endproperty
    property p_tri; $rose(hw_reset_n) |-> ##6 modes.tristate_mode == $past(tri_ok, 6); endproperty
    property p_boot; $rose(hw_reset_n) |-> ##6 modes.boot_width_8bit == $past(boot_width_strap, 6); endproperty
    property p_hiz; modes.tristate_mode |-> pin_oe == '0 && !master_clock_out_oe; endproperty
    property p_mck; !modes.tristate_mode && (periph_reset || !clkout_as_gpio) |-> master_clock_out_oe; endproperty
    property p_inputs; periph_reset |-> pin_oe == '0; endproperty
    property p_sleep; ctrl.fetch_enable && idle_req && !irq_pending |=> !ctrl.core_clk_en; endproperty
    property p_wake; ctrl.fetch_enable && irq_pending |=> ctrl.core_clk_en || !ctrl.fetch_enable; endproperty
    a_enter: assert property (p_enter) else $error("pin reset not immediate");
    a_leave: assert property (p_leave) else $error("reset left unsynchronised");
    a_early: assert property (p_early) else $error("fetch too early");
    a_late: assert property (p_late) else $error("fetch too late");
    a_pc: assert property (p_pc) else $error("reset state wrong");
    a_keep: assert property (p_keep) else $error("modes changed outside pin release");
    a_tri: assert property (p_tri) else $error("tri-state latch wrong");
    a_boot: assert property (p_boot) else $error("boot width latch wrong");
    a_hiz: assert property (p_hiz) else $error("driver on in tri-state");
    a_mck: assert property (p_mck) else $error("clock pin not driven");
    a_inputs: assert property (p_inputs) else $error("pin driven in reset");
    a_sleep: assert property (p_sleep) else $error("core clock not stopped");
    a_wake: assert property (p_wake) else $error("core clock not restarted");
    c_fetch: cover property ($rose(ctrl.fetch_enable));
    c_tri: cover property ($rose(modes.tristate_mode));
    c_sleep: cover property ($fell(ctrl.core_clk_en) && ctrl.fetch_enable);
endmodule : ramlt_chk
bind ramlt_top ramlt_chk #(.STRAP_CYCLES(STRAP_CYCLES), .FETCH_CYCLES(FETCH_CYCLES), .PINS(PINS)) chk (
    .clk, .rst, .hw_reset_n, .wdog_reset_req, .tristate_strap_n, .boot_width_strap, .idle_req,
    .irq_pending, .clkout_as_gpio, .ctrl, .modes, .periph_reset, .pin_oe, .master_clock_out_oe);

//--- tb/ramlt_board.sv
// Board model: reset supervisor and strap drivers
`timescale 1ns/1ns
module ramlt_board (
    input wire logic clk,
    input wire logic start,
    input wire logic boot8,
    input wire logic [7:0] low_len,
    output logic hw_reset_n,
    output logic tristate_strap_n,
    output logic boot_width_strap,
    output logic busy
);
    logic [7:0] left_reg;
    logic [7:0] nl;
    initial begin
        left_reg = 8'h00;
        hw_reset_n = 1'b1;
        tristate_strap_n = 1'b1;
        boot_width_strap = 1'b0;
        busy = 1'b0;
    end
    // Pin low 24 cycles with the clock running; boot strap held 6 cycles past release, tri-state strap high from release
    always @(posedge clk) begin
        nl = (start && left_reg == 8'h00) ? 8'h1E : left_reg - {7'h00, left_reg != 8'h00};
        left_reg <= nl;
        busy <= nl != 8'h00;
        hw_reset_n <= nl <= 8'h06;
        tristate_strap_n <= !(nl > 8'h06 && nl - 8'h06 <= low_len);
        // Released boot strap has no pull, so it toggles
        boot_width_strap <= (nl != 8'h00) ? boot8 : !boot_width_strap;
    end
endmodule : ramlt_board

//--- tb/test_reset_and_mode_latch.sv
// Self-checking bench for the reset and mode latch block
`timescale 1ns/1ns
module test_reset_and_mode_latch;
    import ramlt_pkg::*;
    logic clk, rst, wdog_reset_req, idle_req, irq_pending, clkout_as_gpio, clkout_gpio_out, clkout_gpio_oe;
    logic start, boot8, hw_reset_n, tristate_strap_n, boot_width_strap, busy;
    logic periph_reset, master_clock_out, master_clock_out_oe;
    logic [7:0] low_len;
    logic [31:0] periph_pin_out, periph_pin_oe, pin_out, pin_oe;
    ramlt_ctrl_s ctrl;
    ramlt_modes_s modes, exp_m;
    int num_errors = 0, checks_done = 0, n, seed = 32'h3eee;
    ramlt_top dut (.clk, .rst, .hw_reset_n, .wdog_reset_req, .tristate_strap_n, .boot_width_strap,
        .idle_req, .irq_pending, .clkout_as_gpio, .periph_pin_out, .periph_pin_oe, .clkout_gpio_out,
        .clkout_gpio_oe, .ctrl, .modes, .periph_reset, .pin_out, .pin_oe, .master_clock_out,
        .master_clock_out_oe);
    ramlt_board board (.clk, .start, .boot8, .low_len, .hw_reset_n, .tristate_strap_n,
        .boot_width_strap, .busy);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Random pin traffic every cycle
    always @(posedge clk) begin
        periph_pin_out <= $random(seed);
        periph_pin_oe <= $random(seed);
        clkout_gpio_out <= 1'($random(seed));
        clkout_gpio_oe <= 1'($random(seed));
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    function automatic ramlt_modes_s exp_modes(input logic b, input logic [7:0] len);
        exp_modes.tristate_mode = len >= STRAP_WINDOW_CYCLES;
        exp_modes.boot_width_8bit = b;
    endfunction : exp_modes
    // Wait for fetch under a bound, then check everything the release settles
    task automatic run_check(input logic timed);
        n = 0;
        while (ctrl.fetch_enable !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (timed) chk({31'h0, n >= FETCH_DELAY_CYCLES - 1 && n <= FETCH_DELAY_CYCLES + 1}, 32'h1);
        chk({30'h0, modes}, {30'h0, exp_m});
        chk(ctrl.fetch_addr, PC_RESET_VALUE);
        chk(pin_oe, exp_m.tristate_mode ? 32'h0 : periph_pin_oe);
        chk({31'h0, master_clock_out_oe}, {31'h0, !exp_m.tristate_mode && (!clkout_as_gpio || clkout_gpio_oe)});
        if (!clkout_as_gpio) chk({31'h0, master_clock_out}, 32'h1);
    endtask : run_check
    task automatic pin_reset(input logic b, input logic [7:0] len, input logic wd);
        @(posedge clk);
        start <= 1'b1;
        boot8 <= b;
        low_len <= len;
        wdog_reset_req <= wd;
        repeat (2) @(posedge clk);
        start <= 1'b0;
        wdog_reset_req <= 1'b0;
        #1;
        chk(pin_oe, 32'h0);
        n = 0;
        while (!hw_reset_n && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        exp_m = exp_modes(b, len);
        run_check(1'b1);
        @(posedge clk);
    endtask : pin_reset
    // Cut a hang short well past the expected run length
    initial begin
        #(40 * 5000);
        num_errors++;
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        {start, boot8, low_len, wdog_reset_req, idle_req, irq_pending, clkout_as_gpio} = '0;
        {periph_pin_out, periph_pin_oe, clkout_gpio_out, clkout_gpio_oe} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Mix of long and short strap-low runs; run 2 adds the watchdog
        for (int i = 0; i < 6; i++) begin
            pin_reset(1'($random(seed)), (i == 1 || i == 3) ? 8'h05 : 8'h0C + 8'(i), i == 2);
        end
        // Watchdog alone: tri-state strap now reads high, boot strap toggles, latched modes must stay
        @(posedge clk);
        wdog_reset_req <= 1'b1;
        repeat (4) @(posedge clk);
        wdog_reset_req <= 1'b0;
        #1;
        chk({31'h0, periph_reset}, 32'h1);
        run_check(1'b0);
        // Idle then interrupt wake
        @(posedge clk);
        idle_req <= 1'b1;
        @(posedge clk);
        idle_req <= 1'b0;
        @(posedge clk);
        #1;
        chk({31'h0, ctrl.core_clk_en}, 32'h0);
        @(posedge clk);
        irq_pending <= 1'b1;
        repeat (3) @(posedge clk);
        irq_pending <= 1'b0;
        #1;
        chk({31'h0, ctrl.core_clk_en}, 32'h1);
        // Clock pin reclaimed as I/O after a normal start
        @(posedge clk);
        clkout_as_gpio <= 1'b1;
        pin_reset(1'b0, 8'h00, 1'b0);
        wrap_up();
    end
endmodule : test_reset_and_mode_latch
